// >>> uart_fifo_map.svh
`ifndef UART_FIFO_MAP_SVH
`define UART_FIFO_MAP_SVH

`define OFS_FIFO_CTRL 12'h008
`define OFS_IRQ_EN 12'h00C
`define OFS_STATUS 12'h010
`define OFS_DATA 12'h000
`define RX_LEVEL_HI 27
`define RX_LEVEL_LO 24
`define TX_LEVEL_HI 19
`define TX_LEVEL_LO 16
`define RX_TRIG_HI 7
`define RX_TRIG_LO 6
`define TX_TRIG_HI 5
`define TX_TRIG_LO 4
`define RX_FLUSH_BIT 1
`define TX_FLUSH_BIT 0
`define IRQ_EN_W 10
`define IRQ_EN_RST 10'h000
`define EN_CTS_CHG 9
`define EN_TIMEOUT 8
`define EN_ADDR 7
`define EN_BREAK 6
`define EN_FRAME 5
`define EN_PARITY 4
`define EN_OVERRUN 3
`define EN_TXC 2
`define EN_TXLOW 1
`define EN_RXRDY 0
`define TRIG_RST 2'h0
`define ST_CTS_CHG 10
`define ST_ADDR 9
`define ST_TXC 8
`define ST_TXLOW 7
`define ST_TIMEOUT 6
`define ST_RXRDY 5
`define ST_BREAK 4
`define ST_FRAME 3
`define ST_PARITY 2
`define ST_OVERRUN 1
`define ST_RXNE 0
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

// >>> uart_fifo_pkg.sv
package uart_fifo_pkg;
  typedef enum logic [2:0] {
    BUS_IDLE = 3'h1,
    BUS_WRESP = 3'h2,
    BUS_RDATA = 3'h4
  } bus_state_e;

  typedef struct packed {
    logic rx_char_done;
    logic [8:0] rx_char;
    logic rx_timeout;
    logic parity_err;
    logic framing_err;
    logic break_det;
    logic addr_match;
    logic cts_change;
    logic tx_pop;
    logic tx_shift_empty;
  } line_events_s;

  typedef struct packed {
    logic [3:0] rx_fifo_level;
    logic [3:0] tx_fifo_level;
    logic [2:0] rx_wr_ptr;
    logic [2:0] rx_rd_ptr;
    logic [2:0] tx_wr_ptr;
    logic [2:0] tx_rd_ptr;
    logic [1:0] rx_trigger_level;
    logic [1:0] tx_trigger_level;
    logic [9:0] irq_en;
    logic cts_change_flag;
    logic addr_match_flag;
    logic rx_timeout_flag;
    logic break_flag;
    logic framing_err_flag;
    logic parity_err_flag;
    logic overrun_flag;
    logic tx_complete_flag;
    logic irq;
    logic [1:0] rx_flush_pulse;
    logic [1:0] tx_flush_pulse;
    bus_state_e bus;
    logic awtaken;
    logic wtaken;
    logic [11:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic [1:0] bresp;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [8:0] tx_data;
    logic tx_data_valid;
  } state_s;
endpackage : uart_fifo_pkg

// >>> uart_fifo_ctrl_irq.sv
`include "uart_fifo_map.svh"
module uart_fifo_ctrl_irq #(
  parameter int DEPTH = 8
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  // axi4-lite write
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // events from the line logic
  input wire uart_fifo_pkg::line_events_s line_ev,
  // transmit side toward the shifter, and rx/tx fifo flush pulses
  output logic [8:0] tx_data,
  output logic tx_data_valid,
  output logic rx_fifo_flush,
  output logic tx_fifo_flush,
  // interrupt request
  output logic irq
);

  uart_fifo_pkg::state_s st_ff;
  uart_fifo_pkg::state_s nxt_st;
  logic [8:0] rx_mem_ff [DEPTH];
  logic [8:0] tx_mem_ff [DEPTH];

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [3:0] rx_trig_count(input logic [1:0] code);
    case (code)
      2'h0: rx_trig_count = 4'h1;
      2'h1: rx_trig_count = 4'h2;
      2'h2: rx_trig_count = 4'h4;
      default: rx_trig_count = 4'h6;
    endcase
  endfunction : rx_trig_count

  function automatic logic [3:0] tx_trig_count(input logic [1:0] code);
    case (code)
      2'h0: tx_trig_count = 4'h0;
      2'h1: tx_trig_count = 4'h2;
      2'h2: tx_trig_count = 4'h4;
      default: tx_trig_count = 4'h6;
    endcase
  endfunction : tx_trig_count

  function automatic logic sticky_next(input logic ev, input logic cur, input logic wclr);
    sticky_next = ev | (cur & ~wclr);
  endfunction : sticky_next

  logic [3:0] rx_thr;
  logic [3:0] tx_thr;
  logic tx_low_flag;
  logic rx_ready_flag;
  logic [9:0] irq_src;
  logic wr_go;
  logic rd_go;
  logic rx_pop;
  logic tx_push;
  logic rx_push;
  logic tx_pop;
  logic rx_full;
  logic [31:0] wd;
  logic timeout_ev;
  logic [9:0] irq_en_vec;
  logic [9:0] irq_hit;
  logic cts_change_irq_en;
  logic rx_timeout_irq_en;
  logic addr_match_irq_en;
  logic break_irq_en;
  logic framing_err_irq_en;
  logic parity_err_irq_en;
  logic overrun_irq_en;
  logic tx_complete_irq_en;
  logic tx_low_irq_en;
  logic rx_ready_irq_en;

  // ----------------------------------------
  // thresholds and flags
  // ----------------------------------------
  // rx trigger decode
  assign rx_thr = rx_trig_count(st_ff.rx_trigger_level);
  assign tx_thr = tx_trig_count(st_ff.tx_trigger_level);
  assign tx_low_flag = st_ff.tx_fifo_level < tx_thr;
  assign rx_ready_flag = st_ff.rx_fifo_level >= rx_thr;
  assign rx_full = st_ff.rx_fifo_level == 4'(DEPTH);

  // per-event gating order matches enable bits
  assign irq_src = {st_ff.cts_change_flag, st_ff.rx_timeout_flag, st_ff.addr_match_flag,
                    st_ff.break_flag, st_ff.framing_err_flag, st_ff.parity_err_flag,
                    st_ff.overrun_flag, st_ff.tx_complete_flag, tx_low_flag, rx_ready_flag};

  // ----------------------------------------
  // per-event enables
  // ----------------------------------------
  // cts change enable
  assign cts_change_irq_en = st_ff.irq_en[`EN_CTS_CHG];
  assign rx_timeout_irq_en = st_ff.irq_en[`EN_TIMEOUT];
  assign addr_match_irq_en = st_ff.irq_en[`EN_ADDR];
  assign break_irq_en = st_ff.irq_en[`EN_BREAK];
  assign framing_err_irq_en = st_ff.irq_en[`EN_FRAME];
  assign parity_err_irq_en = st_ff.irq_en[`EN_PARITY];
  assign overrun_irq_en = st_ff.irq_en[`EN_OVERRUN];
  assign tx_complete_irq_en = st_ff.irq_en[`EN_TXC];
  assign tx_low_irq_en = st_ff.irq_en[`EN_TXLOW];
  assign rx_ready_irq_en = st_ff.irq_en[`EN_RXRDY];
  assign irq_en_vec = {cts_change_irq_en, rx_timeout_irq_en, addr_match_irq_en, break_irq_en,
                       framing_err_irq_en, parity_err_irq_en, overrun_irq_en,
                       tx_complete_irq_en, tx_low_irq_en, rx_ready_irq_en};
  for (genvar i = 0; i < `IRQ_EN_W; i++) begin : g_gate
    assign irq_hit[i] = irq_src[i] & irq_en_vec[i];
  end

  // ----------------------------------------
  // bus and fifo strobes
  // ----------------------------------------
  assign wr_go = st_ff.bus == uart_fifo_pkg::BUS_IDLE && st_ff.awtaken && st_ff.wtaken;
  assign rd_go = st_ff.bus == uart_fifo_pkg::BUS_IDLE && !wr_go && s_axi_arvalid;
  assign wd = st_ff.wdata;
  assign timeout_ev = line_ev.rx_timeout && st_ff.rx_fifo_level != 4'h0;
  assign rx_push = line_ev.rx_char_done && !rx_full;
  assign rx_pop = rd_go && s_axi_araddr == `OFS_DATA && st_ff.rx_fifo_level != 4'h0;
  assign tx_push = wr_go && st_ff.awaddr == `OFS_DATA && st_ff.wstrb[0]
                   && st_ff.tx_fifo_level != 4'(DEPTH);
  assign tx_pop = line_ev.tx_pop && st_ff.tx_fifo_level != 4'h0;

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    logic [31:0] rd;
    logic [31:0] clr;
    logic rxf;
    logic txf;
    rd = 32'h0000_0000;
    clr = 32'h0000_0000;
    rxf = 1'b0;
    txf = 1'b0;
    nxt_st = st_ff;
    nxt_st.tx_data_valid = 1'b0;
    nxt_st.rx_flush_pulse = {st_ff.rx_flush_pulse[0], 1'b0};
    nxt_st.tx_flush_pulse = {st_ff.tx_flush_pulse[0], 1'b0};

    if (s_axi_awvalid && !st_ff.awtaken) begin
      nxt_st.awtaken = 1'b1;
      nxt_st.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !st_ff.wtaken) begin
      nxt_st.wtaken = 1'b1;
      nxt_st.wdata = s_axi_wdata;
      nxt_st.wstrb = s_axi_wstrb;
    end

    case (st_ff.bus)
      uart_fifo_pkg::BUS_IDLE: begin
        if (wr_go) begin
          nxt_st.awtaken = 1'b0;
          nxt_st.wtaken = 1'b0;
          nxt_st.bresp = `RESP_OKAY;
          nxt_st.bus = uart_fifo_pkg::BUS_WRESP;
          case (st_ff.awaddr)
            `OFS_FIFO_CTRL: begin
              if (st_ff.wstrb[0]) begin
                nxt_st.rx_trigger_level = wd[`RX_TRIG_HI:`RX_TRIG_LO];
                nxt_st.tx_trigger_level = wd[`TX_TRIG_HI:`TX_TRIG_LO];
                rxf = wd[`RX_FLUSH_BIT];
                txf = wd[`TX_FLUSH_BIT];
              end
            end
            `OFS_IRQ_EN: begin
              if (st_ff.wstrb[0]) nxt_st.irq_en[7:0] = wd[7:0];
              if (st_ff.wstrb[1]) nxt_st.irq_en[9:8] = wd[9:8];
            end
            `OFS_STATUS: begin
              if (st_ff.wstrb[0]) clr[7:0] = wd[7:0];
              if (st_ff.wstrb[1]) clr[15:8] = wd[15:8];
            end
            `OFS_DATA: begin
              nxt_st.tx_complete_flag = 1'b0;
            end
            default: nxt_st.bresp = `RESP_SLVERR;
          endcase
        end else if (rd_go) begin
          nxt_st.rresp = `RESP_OKAY;
          nxt_st.bus = uart_fifo_pkg::BUS_RDATA;
          case (s_axi_araddr)
            `OFS_FIFO_CTRL: begin
              rd[`RX_LEVEL_HI:`RX_LEVEL_LO] = st_ff.rx_fifo_level;
              rd[`TX_LEVEL_HI:`TX_LEVEL_LO] = st_ff.tx_fifo_level;
              rd[`RX_TRIG_HI:`RX_TRIG_LO] = st_ff.rx_trigger_level;
              rd[`TX_TRIG_HI:`TX_TRIG_LO] = st_ff.tx_trigger_level;
            end
            `OFS_IRQ_EN: rd[9:0] = st_ff.irq_en;
            `OFS_STATUS: begin
              rd[`ST_CTS_CHG] = st_ff.cts_change_flag;
              rd[`ST_ADDR] = st_ff.addr_match_flag;
              rd[`ST_TXC] = st_ff.tx_complete_flag;
              rd[`ST_TXLOW] = tx_low_flag;
              rd[`ST_TIMEOUT] = st_ff.rx_timeout_flag;
              rd[`ST_RXRDY] = rx_ready_flag;
              rd[`ST_BREAK] = st_ff.break_flag;
              rd[`ST_FRAME] = st_ff.framing_err_flag;
              rd[`ST_PARITY] = st_ff.parity_err_flag;
              rd[`ST_OVERRUN] = st_ff.overrun_flag;
              rd[`ST_RXNE] = st_ff.rx_fifo_level != 4'h0;
            end
            `OFS_DATA: rd[8:0] = rx_mem_ff[st_ff.rx_rd_ptr];
            default: nxt_st.rresp = `RESP_SLVERR;
          endcase
          nxt_st.rdata = rd;
        end
      end
      uart_fifo_pkg::BUS_WRESP: begin
        if (s_axi_bready) nxt_st.bus = uart_fifo_pkg::BUS_IDLE;
      end
      uart_fifo_pkg::BUS_RDATA: begin
        if (s_axi_rready) nxt_st.bus = uart_fifo_pkg::BUS_IDLE;
      end
      default: nxt_st.bus = uart_fifo_pkg::BUS_IDLE;
    endcase

    nxt_st.cts_change_flag = sticky_next(line_ev.cts_change, st_ff.cts_change_flag,
                                         clr[`ST_CTS_CHG]);
    nxt_st.addr_match_flag = sticky_next(line_ev.addr_match, st_ff.addr_match_flag,
                                         clr[`ST_ADDR]);
    nxt_st.rx_timeout_flag = sticky_next(timeout_ev, st_ff.rx_timeout_flag,
                                         clr[`ST_TIMEOUT]);
    nxt_st.break_flag = sticky_next(line_ev.break_det, st_ff.break_flag,
                                    clr[`ST_BREAK]);
    nxt_st.framing_err_flag = sticky_next(line_ev.framing_err, st_ff.framing_err_flag,
                                          clr[`ST_FRAME]);
    nxt_st.parity_err_flag = sticky_next(line_ev.parity_err, st_ff.parity_err_flag,
                                         clr[`ST_PARITY]);
    nxt_st.overrun_flag = (line_ev.rx_char_done & rx_full)
                          | (st_ff.overrun_flag & ~clr[`ST_OVERRUN]);
    if (st_ff.tx_fifo_level == 4'h0 && line_ev.tx_shift_empty && !tx_push)
      nxt_st.tx_complete_flag = 1'b1;

    // fifo pointers and counts
    if (rx_push) nxt_st.rx_wr_ptr = st_ff.rx_wr_ptr + 3'h1;
    if (rx_pop) nxt_st.rx_rd_ptr = st_ff.rx_rd_ptr + 3'h1;
    nxt_st.rx_fifo_level = st_ff.rx_fifo_level + 4'(rx_push) - 4'(rx_pop);
    if (tx_push) nxt_st.tx_wr_ptr = st_ff.tx_wr_ptr + 3'h1;
    if (tx_pop) begin
      nxt_st.tx_rd_ptr = st_ff.tx_rd_ptr + 3'h1;
      nxt_st.tx_data = tx_mem_ff[st_ff.tx_rd_ptr];
      nxt_st.tx_data_valid = 1'b1;
    end
    nxt_st.tx_fifo_level = st_ff.tx_fifo_level + 4'(tx_push) - 4'(tx_pop);

    if (rxf) begin
      nxt_st.rx_flush_pulse[0] = 1'b1;
      nxt_st.rx_wr_ptr = 3'h0;
      nxt_st.rx_rd_ptr = 3'h0;
      nxt_st.rx_fifo_level = 4'h0;
    end
    if (txf) begin
      nxt_st.tx_flush_pulse[0] = 1'b1;
      nxt_st.tx_wr_ptr = 3'h0;
      nxt_st.tx_rd_ptr = 3'h0;
      nxt_st.tx_fifo_level = 4'h0;
      nxt_st.tx_data_valid = 1'b0;
    end

    nxt_st.irq = |irq_hit;
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      st_ff <= '0;
      st_ff.bus <= uart_fifo_pkg::BUS_IDLE;
      st_ff.irq_en <= `IRQ_EN_RST;
      st_ff.rx_trigger_level <= `TRIG_RST;
      st_ff.tx_trigger_level <= `TRIG_RST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rx_push) rx_mem_ff[st_ff.rx_wr_ptr] <= line_ev.rx_char;
    if (tx_push) tx_mem_ff[st_ff.tx_wr_ptr] <= st_ff.wdata[8:0];
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign s_axi_awready = !st_ff.awtaken;
  assign s_axi_wready = !st_ff.wtaken;
  assign s_axi_bvalid = st_ff.bus == uart_fifo_pkg::BUS_WRESP;
  assign s_axi_bresp = st_ff.bresp;
  assign s_axi_arready = rd_go;
  assign s_axi_rvalid = st_ff.bus == uart_fifo_pkg::BUS_RDATA;
  assign s_axi_rdata = st_ff.rdata;
  assign s_axi_rresp = st_ff.rresp;
  assign tx_data = st_ff.tx_data;
  assign tx_data_valid = st_ff.tx_data_valid;
  assign rx_fifo_flush = st_ff.rx_flush_pulse[0];
  assign tx_fifo_flush = st_ff.tx_flush_pulse[0];
  assign irq = st_ff.irq;

endmodule : uart_fifo_ctrl_irq

// >>> uart_fifo_monitor.sv
module uart_fifo_monitor (
  // clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  // bus handshakes
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // line side and outputs
  input wire uart_fifo_pkg::line_events_s line_ev,
  input wire logic tx_data_valid,
  input wire logic rx_fifo_flush,
  input wire logic tx_fifo_flush,
  input wire logic irq
);
  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!resetn);
  sequence wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence rd_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  AST_WR_LATENCY:
    assert property (wr_taken |-> ##2 s_axi_bvalid) else $error("write answer late");
  AST_WR_BUSY:
    assert property (wr_taken |=> !s_axi_awready && !s_axi_wready ##1 s_axi_awready && s_axi_wready)
      else $error("write channel reopened early");
  AST_B_HOLD:
    assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped");
  AST_R_HOLD:
    assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped");
  AST_RD_LATENCY:
    assert property (rd_taken |=> s_axi_rvalid) else $error("read answer late");
  AST_RX_FLUSH_PULSE:
    assert property (rx_fifo_flush |=> !rx_fifo_flush) else $error("rx flush not single");
  AST_TX_FLUSH_PULSE:
    assert property (tx_fifo_flush |=> !tx_fifo_flush) else $error("tx flush not single");
  AST_TX_VALID_CAUSE:
    assert property (tx_data_valid |-> $past(line_ev.tx_pop)) else $error("tx data unasked");
  AST_IRQ_RESET:
    assert property ($rose(resetn) |-> !irq) else $error("irq high after reset");
endmodule : uart_fifo_monitor

bind uart_fifo_ctrl_irq uart_fifo_monitor mon_u (.clk_sys, .resetn, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .line_ev,
  .tx_data_valid, .rx_fifo_flush, .tx_fifo_flush, .irq);

// >>> uart_line_model.sv
module uart_line_model (
  // clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  // requests from the bench
  input wire logic [6:0] kick,
  input wire logic [8:0] char_in,
  input wire logic pop_req,
  // events toward the block
  output uart_fifo_pkg::line_events_s line_ev
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------
  // far side events
  // ----------------------------------------
  always @(posedge clk_sys) begin
    line_ev <= '0;
    line_ev.tx_shift_empty <= 1'h1;
    line_ev.rx_char <= ~line_ev.rx_char;
    if (!resetn) begin
      line_ev.rx_char <= 9'h155;
    end else begin
      line_ev.rx_char_done <= kick[0];
      if (kick[0]) line_ev.rx_char <= char_in;
      line_ev.parity_err <= kick[1];
      line_ev.framing_err <= kick[2];
      line_ev.break_det <= kick[3];
      line_ev.addr_match <= kick[4];
      line_ev.rx_timeout <= kick[5];
      line_ev.cts_change <= kick[6];
      line_ev.tx_pop <= pop_req;
      line_ev.tx_shift_empty <= !pop_req;
    end
  end
endmodule : uart_line_model

// >>> tb_top.sv
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys, resetn, awvalid, wvalid, bready, arvalid, rready, pop_req;
  logic awready, wready, bvalid, arready, rvalid, tx_data_valid, irq;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata, d;
  logic [1:0] bresp, rresp;
  logic [6:0] kick;
  logic [8:0] char_in, tx_data;
  logic [3:0] wstrb, strb;
  logic rx_flush, tx_flush;
  int rx_flushes = 0;
  int tx_flushes = 0;
  uart_fifo_pkg::line_events_s line_ev;
  int mismatches, tests_run;
  uart_fifo_ctrl_irq dut_u (.clk_sys, .resetn, .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .line_ev, .tx_data, .tx_data_valid, .rx_fifo_flush(rx_flush), .tx_fifo_flush(tx_flush),
    .irq);
  uart_line_model line_u (.clk_sys, .resetn, .kick, .char_in, .pop_req, .line_ev);
  always @(posedge clk_sys) begin
    if (rx_flush === 1'h1) rx_flushes++;
    if (tx_flush === 1'h1) tx_flushes++;
  end
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic tick(inout int n);
    @(posedge clk_sys);
    n++;
    if (n > 300) begin
      mismatches++;
      finish_test();
    end
  endtask : tick
  task automatic axi_wr(input logic [11:0] a, input logic [31:0] v, input logic [1:0] r);
    int n;
    n = 0;
    awaddr <= a;
    wdata <= v;
    wstrb <= strb;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    do begin
      tick(n);
      if (awready === 1'h1) awvalid <= 1'h0;
      if (wready === 1'h1) wvalid <= 1'h0;
    end while (bvalid !== 1'h1);
    bready <= 1'h1;
    tick(n);
    bready <= 1'h0;
    check(bresp, r);
  endtask : axi_wr
  task automatic axi_rd(input logic [11:0] a, input logic [1:0] r);
    int n;
    n = 0;
    araddr <= a;
    arvalid <= 1'h1;
    do begin
      tick(n);
      if (arready === 1'h1) arvalid <= 1'h0;
    end while (rvalid !== 1'h1);
    rready <= 1'h1;
    tick(n);
    rready <= 1'h0;
    d = rdata;
    check(rresp, r);
  endtask : axi_rd
  task automatic kick_ev(input logic [6:0] k, input logic [8:0] c);
    kick <= k;
    char_in <= c;
    @(posedge clk_sys);
    kick <= 7'h00;
    repeat (3) @(posedge clk_sys);
  endtask : kick_ev
  task automatic finish_test;
    $display("tests_run=%0d mismatches=%0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : finish_test
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset;
    axi_rd(12'h008, 2'h0);
    check(d, 32'h0000_0000);
    axi_rd(12'h00C, 2'h0);
    check(d, 32'h0000_0000);
    check(irq, 1'h0);
    axi_rd(12'h020, 2'h2);
    axi_rd(12'h010, 2'h0);
    check(d, 32'h0000_0100);
    axi_wr(12'h020, 32'h0000_0001, 2'h2);
    strb = 4'hE;
    axi_wr(12'h008, 32'h0000_00F3, 2'h0);
    strb = 4'hF;
    axi_rd(12'h008, 2'h0);
    check(d, 32'h0000_0000);
    $display("test reset done");
  endtask : t_reset
  task automatic t_fifo;
    int n;
    n = 0;
    axi_wr(12'h00C, 32'h0000_0008, 2'h0);
    for (int i = 0; i < 9; i++) begin
      axi_wr(12'h000, 32'h0A0 + 32'(i), 2'h0);
      kick_ev(7'h01, 9'h050 + 9'(i));
    end
    axi_rd(12'h008, 2'h0);
    check(d[27:24], 4'h8);
    check(d[19:16], 4'h8);
    check(irq, 1'h1);
    axi_rd(12'h010, 2'h0);
    check(d[1], 1'h1);
    axi_wr(12'h010, 32'h0000_0002, 2'h0);
    check(irq, 1'h0);
    pop_req <= 1'h1;
    tick(n);
    pop_req <= 1'h0;
    do tick(n); while (tx_data_valid !== 1'h1);
    check(tx_data, 9'h0A0);
    axi_wr(12'h008, 32'h0000_0003, 2'h0);
    check(32'(rx_flushes), 32'h1);
    check(32'(tx_flushes), 32'h1);
    axi_rd(12'h008, 2'h0);
    check(d, 32'h0000_0000);
    $display("test fifo done");
  endtask : t_fifo
  task automatic t_trig;
    int rt[4] = '{1, 2, 4, 6};
    int tt[4] = '{0, 2, 4, 6};
    axi_wr(12'h00C, 32'h0000_0003, 2'h0);
    for (int c = 0; c < 4; c++) begin
      axi_wr(12'h008, 32'(c) * 32'h50 + 32'h3, 2'h0);
      for (int k = 1; k < rt[c]; k++) kick_ev(7'h01, 9'h011);
      for (int k = 1; k < tt[c]; k++) axi_wr(12'h000, 32'h22, 2'h0);
      axi_rd(12'h010, 2'h0);
      check(d[5], 1'h0);
      check(d[7], tt[c] > 0);
      check(irq, tt[c] > 0);
      kick_ev(7'h01, 9'h011);
      axi_wr(12'h000, 32'h22, 2'h0);
      axi_rd(12'h010, 2'h0);
      check(d[5], 1'h1);
      check(d[7], 1'h0);
      check(irq, 1'h1);
    end
    $display("test trig done");
  endtask : t_trig
  task automatic t_irq;
    int eb[6] = '{9, 8, 7, 6, 5, 4};
    int sb[6] = '{10, 6, 9, 4, 3, 2};
    axi_wr(12'h00C, 32'h0000_0000, 2'h0);
    for (int i = 0; i < 6; i++) begin
      kick_ev(7'h40 >> i, 9'h000);
      check(irq, 1'h0);
      axi_wr(12'h00C, 32'h1 << eb[i], 2'h0);
      check(irq, 1'h1);
      axi_rd(12'h010, 2'h0);
      check(d[sb[i]], 1'h1);
      axi_wr(12'h010, 32'h1 << sb[i], 2'h0);
      check(irq, 1'h0);
    end
    axi_wr(12'h008, 32'h0000_0001, 2'h0);
    axi_wr(12'h00C, 32'h0000_0004, 2'h0);
    check(irq, 1'h1);
    $display("test irq done");
  endtask : t_irq
  initial begin
    clk_sys = 1'h0;
    forever #10 clk_sys = ~clk_sys;
  end
  initial begin
    {resetn, awvalid, wvalid, bready, arvalid, rready, pop_req} = 7'h00;
    {awaddr, araddr, wdata, kick, char_in} = '0;
    {wstrb, strb} = 8'hFF;
    mismatches = 0;
    tests_run = 0;
    repeat (2) @(posedge clk_sys);
    resetn <= 1'h1;
    t_reset();
    t_fifo();
    t_trig();
    t_irq();
    finish_test();
  end
endmodule : tb_top
